// file: design/fcsh_pkg.sv
// fcsh_pkg: constants and carriers for the flash command sequencer host.
// assumes a parallel nor flash on the far side of the pins, strobe timed.
// What this block does
// - sector is chosen by sector_select_bits alone; host drives them.
// - host writes every command cycle except array and id reads.
// - F0 at any address returns to read mode; host uses it after id or failure.
// - id readout is three writes then one read.
// - host copies addr_ff bit 21 to top_address_bit in id cycles three and four.
// - protect verify: top_address_bit low for sectors 0-31, high 32-63.
// - shortcut program needs shortcut mode entry first.
// - shortcut mode holds until its exit sequence.
package fcsh_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // command register map of the controller
  localparam logic [3:0] REG_ADDR = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_MODE = 4'h5;
  // operation codes written to REG_CMD
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_IDREAD = 4'h2;
  localparam logic [3:0] OP_REG_ENTER = 4'h3;
  localparam logic [3:0] OP_REG_EXIT = 4'h4;
  localparam logic [3:0] OP_CFI = 4'h5;
  localparam logic [3:0] OP_PROG = 4'h6;
  localparam logic [3:0] OP_SC_ENTER = 4'h7;
  localparam logic [3:0] OP_SC_PROG = 4'h8;
  localparam logic [3:0] OP_SC_EXIT = 4'h9;
  localparam logic [3:0] OP_CHIP_ERASE = 4'hA;
  localparam logic [3:0] OP_SECT_ERASE = 4'hB;
  localparam logic [3:0] OP_SUSPEND = 4'hC;
  localparam logic [3:0] OP_RESUME = 4'hD;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_SHORTCUT = 1;
  localparam int ST_ERASING = 2;
  localparam int ST_SUSPENDED = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_FAIL = 5;
  localparam int ST_IDMODE = 6;
  localparam int FAIL_BIT = 5;
  // unlock addresses and command codes
  localparam logic [11:0] UNL1_WORD = 12'h555;
  localparam logic [11:0] UNL2_WORD = 12'h2AA;
  localparam logic [11:0] UNL1_BYTE = 12'hAAA;
  localparam logic [11:0] UNL2_BYTE = 12'h555;
  localparam logic [7:0] CD_UNL1 = 8'hAA;
  localparam logic [7:0] CD_UNL2 = 8'h55;
  localparam logic [7:0] CD_RESET = 8'hF0;
  localparam logic [7:0] CD_ID = 8'h90;
  localparam logic [7:0] CD_REGION = 8'h88;
  localparam logic [7:0] CD_PROG = 8'hA0;
  localparam logic [7:0] CD_SHORT = 8'h20;
  localparam logic [7:0] CD_ESETUP = 8'h80;
  localparam logic [7:0] CD_CHIP = 8'h10;
  localparam logic [7:0] CD_SECT = 8'h30;
  localparam logic [7:0] CD_SUSP = 8'hB0;
  localparam logic [7:0] CD_CFI = 8'h98;
  localparam logic [7:0] CD_ZERO = 8'h00;
  localparam logic [11:0] CFI_WORD = 12'h055;
  localparam logic [11:0] CFI_BYTE = 12'h0AA;
  // bus cycle timing, in mclk cycles at 125 MHz
  localparam int CLK_NS = 8;
  localparam int T_SETUP_NS = 30;
  localparam int T_PULSE_NS = 40;
  localparam int T_HOLD_NS = 30;
  localparam int T_SUSP_US = 20;
  localparam int N_SETUP = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_PULSE = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_HOLD = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int N_SUSP = T_SUSP_US * 1000 / CLK_NS;
  // one bus cycle on the flash pins
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcsh_cyc_type;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic dq_oe;
  } fcsh_pins_type;
endpackage : fcsh_pkg

// file: design/fcsh_top.sv
// fcsh_top: host controller that drives a nor flash through its pins.
// assumes one 125 MHz clock; software talks over a strobe register port.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module fcsh_top #(
  parameter int SUSP_CYCLES = fcsh_pkg::N_SUSP
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // software register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // flash pins
  output logic [fcsh_pkg::ADDR_W-1:0] flash_addr_out,
  output logic [fcsh_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [fcsh_pkg::DATA_W-1:0] flash_dq_in,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out
);
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_SETUP, S_PULSE, S_HOLD,
    S_NEXT} fcsh_state_type;
  localparam int SEQ_MAX = 6;

  logic rst_s1_ff, rst_ff;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_ff;

  logic [fcsh_pkg::DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  always_ff @(posedge mclk_in) begin
    dq_s1_ff <= flash_dq_in;
    dq_s2_ff <= dq_s1_ff;
  end

  // software registers
  logic [fcsh_pkg::ADDR_W-1:0] addr_ff;
  logic [fcsh_pkg::DATA_W-1:0] wdata_ff, rdata_ff;
  logic byte_mode_ff, shortcut_ff, erasing_ff, suspended_ff;
  logic idmode_ff, refused_ff, fail_ff;
  logic [3:0] op_ff;
  fcsh_state_type state_ff;
  logic [2:0] idx_ff, len_ff;
  logic [7:0] cnt_ff;
  logic [15:0] susp_cnt_ff;
  logic [31:0] rd_mux;

  // a sequence of up to six cycles; built from the current op
  function automatic fcsh_pkg::fcsh_cyc_type cyc(input logic wr,
      input logic [11:0] a, input logic [7:0] d);
    cyc.wr = wr;
    cyc.addr = {10'h000, a};
    cyc.data = {8'h00, d};
  endfunction : cyc

  wire [11:0] u1 = byte_mode_ff ? fcsh_pkg::UNL1_BYTE : fcsh_pkg::UNL1_WORD;
  wire [11:0] u2 = byte_mode_ff ? fcsh_pkg::UNL2_BYTE : fcsh_pkg::UNL2_WORD;
  fcsh_pkg::fcsh_cyc_type seq [SEQ_MAX];
  logic [2:0] seq_len;
  logic op_ok;
  fcsh_pkg::fcsh_cyc_type user_rd, user_wr, sa_cyc;
  assign user_rd = '{wr: 1'b0, addr: addr_ff, data: '0};
  assign user_wr = '{wr: 1'b1, addr: addr_ff, data: wdata_ff};
  // only sector_select_bits steer the erase target
  assign sa_cyc = '{wr: 1'b1, addr: {addr_ff[21:16], 16'h0000},
                   data: {8'h00, fcsh_pkg::CD_SECT}};

  always_comb begin
    for (int i = 0; i < SEQ_MAX; i++) seq[i] = user_rd;
    seq_len = 3'd1;
    op_ok = 1'b1;
    seq[0] = cyc(1'b1, u1, fcsh_pkg::CD_UNL1);
    seq[1] = cyc(1'b1, u2, fcsh_pkg::CD_UNL2);
    case (op_ff)
      fcsh_pkg::OP_READ: begin
        seq[0] = user_rd;
      end
      fcsh_pkg::OP_RESET: begin
        seq[0] = cyc(1'b1, 12'h000, fcsh_pkg::CD_RESET);
      end
      fcsh_pkg::OP_IDREAD: begin
        // three writes then one read, top_address_bit taken from addr_ff
        // set it in addr_ff bit 21 to check sectors 32-63
        seq[2] = cyc(1'b1, u1, fcsh_pkg::CD_ID);
        seq[2].addr[21] = addr_ff[21];
        seq[3] = user_rd;
        seq_len = 3'd4;
        op_ok = !shortcut_ff;
      end
      fcsh_pkg::OP_REG_ENTER: begin
        seq[2] = cyc(1'b1, u1, fcsh_pkg::CD_REGION);
        seq_len = 3'd3;
        op_ok = !shortcut_ff && !erasing_ff;
      end
      fcsh_pkg::OP_REG_EXIT: begin
        seq[2] = cyc(1'b1, u1, fcsh_pkg::CD_ID);
        seq[3] = cyc(1'b1, 12'h000, fcsh_pkg::CD_ZERO);
        seq_len = 3'd4;
      end
      fcsh_pkg::OP_CFI: begin
        seq[0] = cyc(1'b1, byte_mode_ff ? fcsh_pkg::CFI_BYTE
                 : fcsh_pkg::CFI_WORD, fcsh_pkg::CD_CFI);
      end
      fcsh_pkg::OP_PROG: begin
        seq[2] = cyc(1'b1, u1, fcsh_pkg::CD_PROG);
        seq[3] = user_wr;
        seq_len = 3'd4;
        op_ok = !shortcut_ff && !(erasing_ff && !suspended_ff);
      end
      fcsh_pkg::OP_SC_ENTER: begin
        seq[2] = cyc(1'b1, u1, fcsh_pkg::CD_SHORT);
        seq_len = 3'd3;
        op_ok = !shortcut_ff && !erasing_ff;
      end
      fcsh_pkg::OP_SC_PROG: begin
        seq[0] = cyc(1'b1, 12'h000, fcsh_pkg::CD_PROG);
        seq[1] = user_wr;
        seq_len = 3'd2;
        op_ok = shortcut_ff;
      end
      fcsh_pkg::OP_SC_EXIT: begin
        seq[0] = cyc(1'b1, 12'h000, fcsh_pkg::CD_ID);
        seq[1] = cyc(1'b1, 12'h000, fcsh_pkg::CD_ZERO);
        seq_len = 3'd2;
        op_ok = shortcut_ff;
      end
      fcsh_pkg::OP_CHIP_ERASE, fcsh_pkg::OP_SECT_ERASE: begin
        seq[2] = cyc(1'b1, u1, fcsh_pkg::CD_ESETUP);
        seq[3] = cyc(1'b1, u1, fcsh_pkg::CD_UNL1);
        seq[4] = cyc(1'b1, u2, fcsh_pkg::CD_UNL2);
        seq[5] = (op_ff == fcsh_pkg::OP_SECT_ERASE) ? sa_cyc
                 : cyc(1'b1, u1, fcsh_pkg::CD_CHIP);
        seq_len = 3'd6;
        op_ok = !shortcut_ff && !erasing_ff;
      end
      fcsh_pkg::OP_SUSPEND: begin
        seq[0] = cyc(1'b1, 12'h000, fcsh_pkg::CD_SUSP);
        op_ok = erasing_ff && !suspended_ff;
      end
      fcsh_pkg::OP_RESUME: begin
        seq[0] = cyc(1'b1, 12'h000, fcsh_pkg::CD_SECT);
        op_ok = suspended_ff;
      end
      default: begin
        op_ok = 1'b0;
      end
    endcase
  end

  wire busy = (state_ff != S_IDLE);
  wire cmd_wr = reg_wr_in && (reg_addr_in == fcsh_pkg::REG_CMD);
  wire start = cmd_wr && !busy;
  wire [3:0] new_op = reg_wdata_in[3:0];
  fcsh_pkg::fcsh_cyc_type cur;
  assign cur = seq[idx_ff];
  wire cnt_done = (cnt_ff == 8'd0);
  wire last = (idx_ff == len_ff - 3'd1);

  // sequencer: strobes fall after setup so the address is stable
  // and rise with data still driven for the hold time
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      idx_ff <= 3'd0;
      len_ff <= 3'd1;
      cnt_ff <= 8'd0;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_dq_oe_out <= 1'b0;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      rdata_ff <= '0;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (start) state_ff <= S_CHECK;
        end
        // legality is judged one cycle late, once op_ff holds the new op
        S_CHECK: begin
          state_ff <= op_ok ? S_SETUP : S_IDLE;
          idx_ff <= 3'd0;
          len_ff <= seq_len;
          cnt_ff <= 8'(fcsh_pkg::N_SETUP);
        end
        S_SETUP: begin
          flash_addr_out <= cur.addr;
          flash_dq_out <= cur.data;
          flash_dq_oe_out <= cur.wr;
          flash_ce_n_out <= 1'b0;
          cnt_ff <= cnt_ff - 8'd1;
          if (cnt_done) begin
            state_ff <= S_PULSE;
            cnt_ff <= 8'(fcsh_pkg::N_PULSE);
          end
        end
        S_PULSE: begin
          flash_we_n_out <= !cur.wr;
          flash_oe_n_out <= cur.wr;
          cnt_ff <= cnt_ff - 8'd1;
          if (cnt_done) begin
            state_ff <= S_HOLD;
            cnt_ff <= 8'(fcsh_pkg::N_HOLD);
            if (!cur.wr) rdata_ff <= dq_s2_ff;
          end
        end
        S_HOLD: begin
          flash_we_n_out <= 1'b1;
          flash_oe_n_out <= 1'b1;
          cnt_ff <= cnt_ff - 8'd1;
          if (cnt_done) state_ff <= S_NEXT;
        end
        S_NEXT: begin
          flash_ce_n_out <= 1'b1;
          flash_dq_oe_out <= 1'b0;
          if (last) begin
            state_ff <= S_IDLE;
          end else begin
            idx_ff <= idx_ff + 3'd1;
            state_ff <= S_SETUP;
            cnt_ff <= 8'(fcsh_pkg::N_SETUP);
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // mode tracking of the far device
  wire done = (state_ff == S_NEXT) && last;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      shortcut_ff <= 1'b0;
      erasing_ff <= 1'b0;
      suspended_ff <= 1'b0;
      idmode_ff <= 1'b0;
      susp_cnt_ff <= 16'd0;
    end else begin
      if (susp_cnt_ff != 16'd0) susp_cnt_ff <= susp_cnt_ff - 16'd1;
      if (done) begin
        case (op_ff)
          fcsh_pkg::OP_RESET: begin
            idmode_ff <= 1'b0;
            if (!suspended_ff) erasing_ff <= 1'b0;
          end
          fcsh_pkg::OP_IDREAD: idmode_ff <= 1'b1;
          fcsh_pkg::OP_SC_ENTER: shortcut_ff <= 1'b1;
          fcsh_pkg::OP_SC_EXIT: shortcut_ff <= 1'b0;
          fcsh_pkg::OP_SECT_ERASE: erasing_ff <= 1'b1;
          fcsh_pkg::OP_SUSPEND: begin
            suspended_ff <= 1'b1;
            susp_cnt_ff <= 16'(SUSP_CYCLES);
          end
          fcsh_pkg::OP_RESUME: suspended_ff <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  // register port
  wire fail_seen = done && (op_ff == fcsh_pkg::OP_READ)
                   && rdata_ff[fcsh_pkg::FAIL_BIT];
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= '0;
      wdata_ff <= '0;
      op_ff <= fcsh_pkg::OP_READ;
      byte_mode_ff <= 1'b0;
      refused_ff <= 1'b0;
      fail_ff <= 1'b0;
      reg_rdata_out <= '0;
    end else begin
      if (reg_wr_in && reg_addr_in == fcsh_pkg::REG_ADDR)
        addr_ff <= reg_wdata_in[fcsh_pkg::ADDR_W-1:0];
      if (reg_wr_in && reg_addr_in == fcsh_pkg::REG_DATA)
        wdata_ff <= reg_wdata_in[fcsh_pkg::DATA_W-1:0];
      if (reg_wr_in && reg_addr_in == fcsh_pkg::REG_MODE && !busy)
        byte_mode_ff <= reg_wdata_in[0];
      if (start) op_ff <= new_op;
      // set wins over clear
      if (reg_wr_in && reg_addr_in == fcsh_pkg::REG_STAT) begin
        refused_ff <= refused_ff & ~reg_wdata_in[fcsh_pkg::ST_REFUSED];
        fail_ff <= fail_ff & ~reg_wdata_in[fcsh_pkg::ST_FAIL];
      end
      if (cmd_wr && busy) refused_ff <= 1'b1;
      if (state_ff == S_CHECK && !op_ok) refused_ff <= 1'b1;
      if (fail_seen) fail_ff <= 1'b1;
      reg_rdata_out <= '0;
      if (reg_rd_in) reg_rdata_out <= rd_mux;
    end
  end

  wire [6:0] stat = {idmode_ff, fail_ff, refused_ff, suspended_ff,
                     erasing_ff, shortcut_ff,
                     busy || (susp_cnt_ff != 16'd0)};
  assign rd_mux =
    (reg_addr_in == fcsh_pkg::REG_ADDR)  ? {10'h000, addr_ff} :
    (reg_addr_in == fcsh_pkg::REG_DATA)  ? {16'h0000, wdata_ff} :
    (reg_addr_in == fcsh_pkg::REG_CMD)   ? {28'h0000000, op_ff} :
    (reg_addr_in == fcsh_pkg::REG_STAT)  ? {25'h0000000, stat} :
    (reg_addr_in == fcsh_pkg::REG_RDATA) ? {16'h0000, rdata_ff} :
    (reg_addr_in == fcsh_pkg::REG_MODE)  ? {31'h00000000, byte_mode_ff} :
    32'h00000000;
endmodule : fcsh_top

// file: dv/fcsh_assertions.sv
// fcsh_assertions: pin-level checks on the flash side of the host.
// assumes a bind to fcsh_top; sees only its ports.
`timescale 1ns/1ps
module fcsh_checker (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // flash pins
  input wire logic [21:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire logic [15:0] flash_dq_in,
  input wire logic flash_ce_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_oe_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire cmd_wr = reg_wr_in && reg_addr_in == fcsh_pkg::REG_CMD;
  property p_addr_hold;
    !flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during write pulse");
  property p_data_hold;
    !flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_dq_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved during write pulse");
  property p_we_pulse;
    $fell(flash_we_n_out) |-> !flash_we_n_out [*6] ##1 flash_we_n_out;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write pulse length wrong");
  property p_we_drive;
    !flash_we_n_out |-> !flash_ce_n_out && flash_dq_oe_out && flash_oe_n_out;
  endproperty
  a_we_drive: assert property (p_we_drive)
    else $error("write pulse without select or data drive");
  property p_read_float;
    !flash_oe_n_out |-> !flash_dq_oe_out && flash_we_n_out && !flash_ce_n_out;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("read cycle while driving data");
  property p_ce_release;
    $rose(flash_we_n_out) |-> ##[1:8] flash_ce_n_out;
  endproperty
  a_ce_release: assert property (p_ce_release)
    else $error("select not released after write");
  property p_reset_code;
    cmd_wr && reg_wdata_in[3:0] == fcsh_pkg::OP_RESET |->
      ##[1:20] (!flash_we_n_out && flash_dq_out[7:0] == 8'hF0);
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("reset code not written");
  property p_prog_unlock;
    cmd_wr && reg_wdata_in[3:0] == fcsh_pkg::OP_PROG |->
      ##[1:20] (!flash_we_n_out && flash_dq_out[7:0] == 8'hAA);
  endproperty
  a_prog_unlock: assert property (p_prog_unlock)
    else $error("program without unlock code");
  c_read: cover property ($fell(flash_oe_n_out));
  c_short: cover property (!flash_we_n_out && flash_dq_out[7:0] == 8'h20);
  c_susp: cover property (!flash_we_n_out && flash_dq_out[7:0] == 8'hB0);
endmodule : fcsh_checker

// file: dv/fcsh_flash_model.sv
// fcsh_flash_model: behavioural nor flash with its command interpreter.
// assumes active-low strobes; unlock and command addresses are ignored.
`timescale 1ns/1ps
module fcsh_flash_model #(
  parameter logic [15:0] MFR_ID = 16'h0043, // arbitrary value
  parameter logic [5:0] PROT_SECT = 6'h28
) (
  // flash pins
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [21:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [logic [21:0]];
  logic [21:0] la;
  logic [7:0] d;
  logic [2:0] n = 3'h0;
  logic idm = 1'b0, scm = 1'b0, cfim = 1'b0;
  logic ers = 1'b0, chip = 1'b0, sus = 1'b0;
  logic [5:0] esec = 6'h0;
  logic [15:0] last = 16'h0;
  always @(negedge we_n_in) if (!ce_n_in) la = addr_in;
  always @(posedge we_n_in) if (!ce_n_in) begin
    d = dq_in[7:0];
    if (d == 8'hF0) begin
      {n, idm, scm, cfim} = 6'h0;
      if (!sus) {ers, chip} = 2'h0;
    end else if (n == 3'h6) begin
      mem[la] = dq_in;
      n = 3'h0;
    end else if (n == 3'h7) begin
      scm = scm && d != 8'h00;
      n = 3'h0;
    end else if (scm) begin
      n = d == 8'hA0 ? 3'h6 : d == 8'h90 ? 3'h7 : 3'h0;
    end else if (idm && d == 8'h00) begin
      idm = 1'b0;
    end else if (n == 3'h0) begin
      if (d == 8'hB0 && ers && !chip) sus = 1'b1;
      if (d == 8'h30 && sus) sus = 1'b0;
      cfim = cfim || d == 8'h98;
      n = d == 8'hAA ? 3'h1 : 3'h0;
    end else if (n == 3'h2) begin
      idm = idm || d == 8'h90;
      scm = d == 8'h20;
      n = d == 8'hA0 ? 3'h6 : d == 8'h80 ? 3'h3 : 3'h0;
    end else if (n == 3'h5) begin
      if (d == 8'h30) esec = la[21:16];
      ers = d == 8'h30 || d == 8'h10;
      chip = d == 8'h10;
      n = 3'h0;
    end else begin
      n = d == (n == 3'h3 ? 8'hAA : 8'h55) ? n + 3'h1 : 3'h0;
    end
  end
  // a released bus shows the inverse of the last value, never a stale match
  always @(ce_n_in, oe_n_in, addr_in, idm, cfim, sus, last) begin
    if (ce_n_in || oe_n_in) dq_out = ~last;
    else if (idm) dq_out = addr_in[7:0] == 8'h00 ? MFR_ID
      : addr_in[7:0] == 8'h02 ? {15'h0, addr_in[21:16] == PROT_SECT}
      : addr_in[7:0] == 8'h03 ? 16'h0085 : 16'h0000;
    else if (cfim) dq_out = 16'h0051;
    else if (sus && addr_in[21:16] == esec) dq_out = 16'h0080;
    else if (mem.exists(addr_in)) dq_out = mem[addr_in];
    else dq_out = 16'hFFFF;
  end
  always @(dq_out) if (!oe_n_in && !ce_n_in) last = dq_out;
endmodule : fcsh_flash_model

// file: dv/test_flash_command_sequencer.sv
// test_flash_command_sequencer: self-checking bench for the flash host.
// assumes the flash model and checker files are compiled before it.
`timescale 1ns/1ps
module test_flash_command_sequencer;
  localparam logic [15:0] MFR = 16'h0043; // arbitrary value
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv;
  logic [21:0] faddr;
  logic [15:0] fdq_o, fdq_m, fbus;
  logic fdq_oe, fce_n, fwe_n, foe_n;
  int fail_count = 0;
  int total_checks = 0;
  assign fbus = fdq_oe ? fdq_o : fdq_m;
  initial forever #4 mclk_in = ~mclk_in;
  fcsh_top #(.SUSP_CYCLES(20)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .flash_addr_out(faddr),
    .flash_dq_out(fdq_o), .flash_dq_oe_out(fdq_oe), .flash_dq_in(fbus),
    .flash_ce_n_out(fce_n), .flash_we_n_out(fwe_n), .flash_oe_n_out(foe_n));
  fcsh_flash_model #(.MFR_ID(MFR), .PROT_SECT(6'h28)) i_flash (
    .ce_n_in(fce_n), .we_n_in(fwe_n), .oe_n_in(foe_n), .addr_in(faddr),
    .dq_in(fbus), .dq_out(fdq_m));
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic [3:0] c);
    wr(fcsh_pkg::REG_CMD, {28'h0, c});
    repeat (2) @(posedge mclk_in);
    for (int i = 0; i < 400; i++) begin
      rd(fcsh_pkg::REG_STAT);
      if (rv[fcsh_pkg::ST_BUSY] === 1'b0) break;
    end
    if (rv[fcsh_pkg::ST_BUSY] !== 1'b0) fail_count++;
  endtask : op
  task automatic seq(input logic [21:0] a, input logic [3:0] c);
    wr(fcsh_pkg::REG_ADDR, {10'h0, a});
    op(c);
  endtask : seq
  task automatic rchk(input logic [15:0] e);
    rd(fcsh_pkg::REG_RDATA);
    chk(rv, {16'h0, e});
  endtask : rchk
  task automatic fchk(input logic [21:0] a, input logic [15:0] e);
    seq(a, fcsh_pkg::OP_READ);
    rchk(e);
  endtask : fchk
  task automatic sbit(input int b, input logic e);
    rd(fcsh_pkg::REG_STAT);
    chk({31'h0, rv[b]}, {31'h0, e});
  endtask : sbit
  task automatic complete_run;
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    fail_count++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(fcsh_pkg::REG_STAT);
    chk(rv, 32'h0);
    rd(4'hF);
    chk(rv, 32'h0);
    wr(fcsh_pkg::REG_DATA, 32'hBE8F);
    seq(22'h000123, fcsh_pkg::OP_PROG);
    fchk(22'h000123, 16'hBE8F);
    wr(fcsh_pkg::REG_MODE, 32'h1);
    wr(fcsh_pkg::REG_DATA, 32'h0014);
    seq(22'h000200, fcsh_pkg::OP_PROG);
    fchk(22'h000200, 16'h0014);
    wr(fcsh_pkg::REG_MODE, 32'h0);
    seq(22'h000000, fcsh_pkg::OP_IDREAD);
    rchk(MFR);
    sbit(fcsh_pkg::ST_IDMODE, 1'b1);
    op(fcsh_pkg::OP_RESET);
    sbit(fcsh_pkg::ST_IDMODE, 1'b0);
    seq(22'h280002, fcsh_pkg::OP_IDREAD);
    rchk(16'h0001);
    op(fcsh_pkg::OP_RESET);
    seq(22'h030002, fcsh_pkg::OP_IDREAD);
    rchk(16'h0000);
    op(fcsh_pkg::OP_RESET);
    seq(22'h000003, fcsh_pkg::OP_IDREAD);
    rchk(16'h0085);
    op(fcsh_pkg::OP_RESET);
    op(fcsh_pkg::OP_REG_ENTER);
    op(fcsh_pkg::OP_REG_EXIT);
    fchk(22'h000123, 16'hBE8F);
    op(fcsh_pkg::OP_CFI);
    fchk(22'h000010, 16'h0051);
    op(fcsh_pkg::OP_RESET);
    op(fcsh_pkg::OP_SC_PROG);
    sbit(fcsh_pkg::ST_REFUSED, 1'b1);
    wr(fcsh_pkg::REG_STAT, 32'h30);
    op(fcsh_pkg::OP_SC_ENTER);
    wr(fcsh_pkg::REG_DATA, 32'h1214);
    seq(22'h000300, fcsh_pkg::OP_SC_PROG);
    sbit(fcsh_pkg::ST_SHORTCUT, 1'b1);
    op(fcsh_pkg::OP_SC_EXIT);
    sbit(fcsh_pkg::ST_SHORTCUT, 1'b0);
    fchk(22'h000300, 16'h1214);
    op(fcsh_pkg::OP_SUSPEND);
    sbit(fcsh_pkg::ST_SUSPENDED, 1'b0);
    wr(fcsh_pkg::REG_STAT, 32'h30);
    seq(22'h050000, fcsh_pkg::OP_SECT_ERASE);
    sbit(fcsh_pkg::ST_ERASING, 1'b1);
    op(fcsh_pkg::OP_SUSPEND);
    sbit(fcsh_pkg::ST_SUSPENDED, 1'b1);
    fchk(22'h000123, 16'hBE8F);
    fchk(22'h050000, 16'h0080);
    op(fcsh_pkg::OP_RESUME);
    sbit(fcsh_pkg::ST_SUSPENDED, 1'b0);
    op(fcsh_pkg::OP_RESUME);
    sbit(fcsh_pkg::ST_REFUSED, 1'b1);
    wr(fcsh_pkg::REG_STAT, 32'h30);
    op(fcsh_pkg::OP_RESET);
    op(fcsh_pkg::OP_CHIP_ERASE);
    op(fcsh_pkg::OP_SUSPEND);
    sbit(fcsh_pkg::ST_SUSPENDED, 1'b0);
    fchk(22'h000400, 16'hFFFF);
    sbit(fcsh_pkg::ST_FAIL, 1'b1);
    wr(fcsh_pkg::REG_STAT, 32'h30);
    sbit(fcsh_pkg::ST_FAIL, 1'b0);
    complete_run;
  end
endmodule : test_flash_command_sequencer
bind fcsh_top fcsh_checker i_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out), .flash_dq_in(flash_dq_in),
  .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out),
  .flash_oe_n_out(flash_oe_n_out));
